// file: usart_core.sv
// Purpose: serial transmit path and receive front end with AHB-Lite registers
// Assumes: single-word zero-wait bus transfers; host sets format first
// Notes:   receive error flags and clock recovery are not built
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "usart_defines.svh"
module usart_core #(
   parameter int DIV_W = 12
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // interrupt side
   input  wire logic        global_irq_enable,
   input  wire logic        tx_complete_irq_ack,
   output logic             buffer_empty_irq,
   output logic             tx_complete_irq,
   // transmit pin and its port fallback
   input  wire logic        port_txd_value,
   input  wire logic        port_txd_oe_n,
   output logic             transmit_data_pin_out,
   output logic             transmit_data_pin_oe_n,
   // receive and clock pins
   input  wire logic        receive_data_pin,
   input  wire logic        external_transfer_clock_pin
);
   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic             double_speed_bit_r;
   logic             tx_complete_flag_r;
   logic             buffer_empty_flag;
   logic [7:0]       serial_control_register_b_r;
   logic [7:0]       serial_control_register_c_r;
   logic [DIV_W-1:0] baud_divisor_r;
   logic [8:0]       tx_buf_r;
   logic             tx_full_r;
   logic [8:0]       rx_buf_r;
   logic             receive_complete_flag_r;

   logic       wr_pend_r;
   logic [7:0] wr_addr_r;
   logic       addr_ok;
   logic       rd_data;
   logic [7:0] rd_value;

   logic transmit_enable_bit;
   logic receive_enable_bit;
   logic sync_mode_select;
   logic clock_polarity_bit;
   logic parity_enable_bit;
   logic [2:0] character_size_field;
   logic [3:0] data_bits;

   assign transmit_enable_bit  = serial_control_register_b_r[`CB_TRANSMIT_ENABLE_BIT];
   assign receive_enable_bit   = serial_control_register_b_r[`CB_RXEN];
   assign sync_mode_select     = serial_control_register_c_r[`CC_SYNC];
   assign clock_polarity_bit   = serial_control_register_c_r[`CC_POL];
   assign parity_enable_bit    = serial_control_register_c_r[`CC_PAR_EN];
   assign character_size_field = {serial_control_register_b_r[`CB_SIZE2],
                                  serial_control_register_c_r[`CC_SIZE_HI:`CC_SIZE_LO]};
   assign data_bits = (character_size_field == `SIZE_NINE) ? 4'h9 :
                      `SIZE_BASE + {2'b00, character_size_field[1:0]};

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: always ready, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ok   = hsel & hready & htrans[1];
   assign rd_data   = addr_ok & ~hwrite & (haddr == `ADDR_DATA);

   logic wr_data;
   logic wr_status;
   assign wr_data   = wr_pend_r & (wr_addr_r == `ADDR_DATA);
   assign wr_status = wr_pend_r & (wr_addr_r == `ADDR_STATUS);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ok & hwrite;
         wr_addr_r <= haddr;
      end
   end

   // read-only buffer-empty bit, control B bit 1 reads the received ninth bit
   always_comb begin
      rd_value = 8'h00;
      unique case (haddr)
         `ADDR_DATA:   rd_value = rx_buf_r[7:0];
         `ADDR_STATUS: begin
            rd_value[`ST_RXC]   = receive_complete_flag_r;
            rd_value[`ST_TXC]   = tx_complete_flag_r;
            rd_value[`ST_EMPTY] = buffer_empty_flag;
            rd_value[`ST_U2X]   = double_speed_bit_r;
         end
         `ADDR_CTRL_B: begin
            rd_value = serial_control_register_b_r;
            rd_value[`CB_RX9] = rx_buf_r[8];
         end
         `ADDR_CTRL_C: rd_value = serial_control_register_c_r;
         default:      rd_value = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok & ~hwrite) begin
         if (haddr == `ADDR_BAUD) begin
            hrdata <= {{(32-DIV_W){1'b0}}, baud_divisor_r};
         end else begin
            hrdata <= {24'h00_0000, rd_value};
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         serial_control_register_b_r <= 8'h00;
         serial_control_register_c_r <= `CTRL_C_RESET;
         baud_divisor_r              <= '0;
         double_speed_bit_r          <= 1'b0;
      end else if (wr_pend_r) begin
         unique case (wr_addr_r)
            `ADDR_CTRL_B: serial_control_register_b_r <= hwdata[7:0];
            `ADDR_CTRL_C: serial_control_register_c_r <= hwdata[7:0];
            `ADDR_BAUD:   baud_divisor_r <= hwdata[DIV_W-1:0];
            `ADDR_STATUS: double_speed_bit_r <= hwdata[`ST_U2X];
            default:      ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit timing
   logic       os_tick;
   logic       xck_rise;
   logic       xck_fall;
   logic [4:0] os_len;
   logic       change_edge;
   logic       sample_edge;

   baud_tick_gen #(.DIV_W(DIV_W)) u_baud (
      .clk     (clk),
      .reset   (reset),
      .divisor (baud_divisor_r),
      .tick    (os_tick)
   );

   xck_edge_detect u_xck (
      .clk    (clk),
      .reset  (reset),
      .xck_in (external_transfer_clock_pin),
      .rise   (xck_rise),
      .fall   (xck_fall)
   );

   assign os_len      = double_speed_bit_r ? `OS_DOUBLE : `OS_NORMAL;
   assign change_edge = clock_polarity_bit ? xck_fall : xck_rise;
   assign sample_edge = clock_polarity_bit ? xck_rise : xck_fall;

   ////////////////////////////////////////////////////////////////////////////
   // transmit buffer and shifter
   logic [`FRAME_W-1:0] tx_shift_r;
   logic [`FRAME_W-1:0] frame_nxt;
   logic [3:0]          tx_left_r;
   logic [3:0]          len_nxt;
   logic                tx_busy_r;
   logic [4:0]          tx_os_r;
   logic                tx_bit_tick;
   logic                frame_end;
   logic                tx_load;
   logic                tx_owns;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_os_r <= 5'h00;
      end else if (tx_load & ~tx_busy_r) begin
         // restart the bit clock so a frame from idle opens with a full start bit
         tx_os_r <= 5'h00;
      end else if (os_tick) begin
         tx_os_r <= (tx_os_r >= os_len - 5'h01) ? 5'h00 : tx_os_r + 5'h01;
      end
   end

   assign tx_bit_tick = sync_mode_select ? change_edge :
                        (os_tick & (tx_os_r == os_len - 5'h01));
   assign frame_end   = tx_busy_r & tx_bit_tick & (tx_left_r == 4'h1);
   assign tx_load     = tx_full_r & (~tx_busy_r | frame_end);

   // frame image: start low, data lsb first, parity, stops, high fill
   always_comb begin
      logic par;
      par = ^(tx_buf_r & ~(9'h1FF << data_bits)) ^
            serial_control_register_c_r[`CC_PAR_ODD];
      frame_nxt    = '1;
      frame_nxt[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(data_bits)) begin
            frame_nxt[i+1] = tx_buf_r[i];
         end
      end
      if (parity_enable_bit) begin
         frame_nxt[data_bits + 4'h1] = par;
      end
      len_nxt = data_bits + 4'h2 + {3'b000, parity_enable_bit} +
                {3'b000, serial_control_register_c_r[`CC_STOP2]};
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_buf_r  <= 9'h000;
         tx_full_r <= 1'b0;
      end else if (wr_data) begin
         // ninth bit taken from control now so it travels with this byte
         tx_buf_r  <= {serial_control_register_b_r[`CB_TX9], hwdata[7:0]};
         tx_full_r <= 1'b1;
      end else if (tx_load) begin
         tx_full_r <= 1'b0;
      end
   end

   assign buffer_empty_flag = ~tx_full_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_shift_r <= '1;
         tx_left_r  <= 4'h0;
         tx_busy_r  <= 1'b0;
      end else if (tx_load) begin
         tx_shift_r <= frame_nxt;
         tx_left_r  <= len_nxt;
         tx_busy_r  <= 1'b1;
      end else if (tx_busy_r & tx_bit_tick) begin
         tx_shift_r <= {1'b1, tx_shift_r[`FRAME_W-1:1]};
         tx_left_r  <= tx_left_r - 4'h1;
         tx_busy_r  <= (tx_left_r != 4'h1);
      end
   end

   // set wins over both clears
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_complete_flag_r <= 1'b0;
      end else if (frame_end & ~tx_full_r) begin
         tx_complete_flag_r <= 1'b1;
      end else if (tx_complete_irq_ack |
                   (wr_status & hwdata[`ST_TXC])) begin
         tx_complete_flag_r <= 1'b0;
      end
   end

   assign buffer_empty_irq = global_irq_enable & buffer_empty_flag &
                             serial_control_register_b_r[`CB_UDRIE];
   assign tx_complete_irq  = global_irq_enable & tx_complete_flag_r &
                             serial_control_register_b_r[`CB_TXCIE];

   // pending frames keep the pin after the enable drops
   assign tx_owns = transmit_enable_bit | tx_busy_r | tx_full_r;
   assign transmit_data_pin_out  = tx_owns ? tx_shift_r[0] : port_txd_value;
   assign transmit_data_pin_oe_n = tx_owns ? 1'b0 : port_txd_oe_n;

   ////////////////////////////////////////////////////////////////////////////
   // receiver
   usart_pkg::rx_state_type rx_state_r;
   logic [4:0] rx_os_r;
   logic [3:0] rx_idx_r;
   logic [8:0] rx_shift_r;
   logic       rx_in;
   logic       rx_tick;
   logic       rx_sample;

   assign rx_in     = receive_enable_bit ? receive_data_pin : 1'b1;
   assign rx_tick   = sync_mode_select ? sample_edge : os_tick;
   assign rx_sample = sync_mode_select ? sample_edge :
                      (os_tick & (rx_os_r == os_len - 5'h01));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_state_r <= usart_pkg::RX_IDLE;
         rx_os_r    <= 5'h00;
         rx_idx_r   <= 4'h0;
         rx_shift_r <= 9'h000;
      end else if (~receive_enable_bit) begin
         rx_state_r <= usart_pkg::RX_IDLE;
      end else begin
         unique case (rx_state_r)
            usart_pkg::RX_IDLE: if (rx_tick & ~rx_in) begin
               rx_os_r    <= 5'h00;
               rx_idx_r   <= 4'h0;
               rx_shift_r <= 9'h000;
               rx_state_r <= sync_mode_select ? usart_pkg::RX_DATA :
                                                usart_pkg::RX_START;
            end
            usart_pkg::RX_START: if (os_tick) begin
               // recheck the start bit at its middle
               if (rx_os_r == (os_len >> 1) - 5'h01) begin
                  rx_os_r    <= 5'h00;
                  rx_state_r <= rx_in ? usart_pkg::RX_IDLE : usart_pkg::RX_DATA;
               end else begin
                  rx_os_r <= rx_os_r + 5'h01;
               end
            end
            usart_pkg::RX_DATA: begin
               if (os_tick) begin
                  rx_os_r <= (rx_os_r == os_len - 5'h01) ? 5'h00 : rx_os_r + 5'h01;
               end
               if (rx_sample) begin
                  if (rx_idx_r < data_bits) begin
                     rx_shift_r[rx_idx_r] <= rx_in;
                  end
                  rx_idx_r <= rx_idx_r + 4'h1;
                  if (rx_idx_r == data_bits + {3'b000, parity_enable_bit}) begin
                     rx_state_r <= usart_pkg::RX_IDLE;
                  end
               end
            end
            default: rx_state_r <= usart_pkg::RX_IDLE;
         endcase
      end
   end

   logic rx_done;
   assign rx_done = receive_enable_bit & (rx_state_r == usart_pkg::RX_DATA) & rx_sample &
                    (rx_idx_r == data_bits + {3'b000, parity_enable_bit});

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_buf_r                <= 9'h000;
         receive_complete_flag_r <= 1'b0;
      end else if (~receive_enable_bit) begin
         receive_complete_flag_r <= 1'b0;
      end else if (rx_done) begin
         rx_buf_r                <= rx_shift_r;
         receive_complete_flag_r <= 1'b1;
      end else if (rd_data) begin
         receive_complete_flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   txd_owned_a: assert property (transmit_enable_bit |-> !transmit_data_pin_oe_n)
      else $error("transmit pin not driven while enabled");
   wr_clears_empty_a: assert property (wr_data |=> !buffer_empty_flag)
      else $error("data write left buffer empty");
   idle_load_a: assert property (tx_full_r && !tx_busy_r && !wr_data
                                 |=> tx_busy_r && buffer_empty_flag)
      else $error("idle shifter did not take buffer");
   txc_set_a: assert property (frame_end && !tx_full_r |=> tx_complete_flag_r)
      else $error("complete flag missing after frame");
   txc_clear_a: assert property (tx_complete_irq_ack && !frame_end
                                 |=> !tx_complete_flag_r)
      else $error("complete flag not cleared by service");
   empty_irq_a: assert property (buffer_empty_irq |-> buffer_empty_flag
                                 && global_irq_enable)
      else $error("empty request without cause");
   txc_irq_a: assert property ($rose(tx_complete_flag_r) && global_irq_enable
              && serial_control_register_b_r[`CB_TXCIE] |-> tx_complete_irq)
      else $error("complete request missing");
   tx_release_a: assert property (!tx_owns |-> transmit_data_pin_oe_n == port_txd_oe_n)
      else $error("transmit pin held after disable");
   tx_start_low_a: assert property (tx_load && !tx_busy_r |=> !transmit_data_pin_out)
      else $error("frame did not open with low start");
   rx_off_a: assert property (!receive_enable_bit |=> rx_state_r == usart_pkg::RX_IDLE
                              && !receive_complete_flag_r)
      else $error("receiver active while disabled");

   tx_frame_c: cover property (frame_end && !tx_full_r);
   tx_backtoback_c: cover property (frame_end && tx_full_r);
   rx_frame_c: cover property (rx_done);
endmodule // usart_core
`default_nettype wire

// file: usart_defines.svh
// Purpose: register map, field positions and reset values of the serial port
// Assumes: 32-bit word-aligned register bus
// Notes:   definitions only
`ifndef USART_DEFINES_SVH
`define USART_DEFINES_SVH

`define ADDR_DATA     8'h00
`define ADDR_STATUS   8'h04
`define ADDR_CTRL_B   8'h08
`define ADDR_CTRL_C   8'h0C
`define ADDR_BAUD     8'h10

`define ST_RXC        7
`define ST_TXC        6
`define ST_EMPTY      5
`define ST_U2X        1
`define CB_TXCIE      6
`define CB_UDRIE      5
`define CB_RXEN       4
`define CB_TRANSMIT_ENABLE_BIT       3
`define CB_SIZE2      2
`define CB_RX9        1
`define CB_TX9        0
`define CC_SYNC       6
`define CC_PAR_EN     5
`define CC_PAR_ODD    4
`define CC_STOP2      3
`define CC_SIZE_HI    2
`define CC_SIZE_LO    1
`define CC_POL        0

`define CTRL_C_RESET  8'h06
`define SIZE_NINE     3'h7
`define SIZE_BASE     4'h5
`define OS_NORMAL     5'h10
`define OS_DOUBLE     5'h08
`define FRAME_W       13

`endif

// file: usart_pkg.sv
// Purpose: shared state types of the serial port
// Assumes: nothing
// Notes:   constants live in usart_defines.svh
package usart_pkg;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10
   } rx_state_type;
endpackage

// file: baud_tick_gen.sv
// Purpose: oversample tick from the system clock
// Assumes: divisor changes only while the link is quiet
// Notes:   one tick every divisor+1 clocks
`timescale 1ns/100ps
`default_nettype none
module baud_tick_gen #(
   parameter int DIV_W = 12
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // control
   input  wire logic [DIV_W-1:0] divisor,
   // tick
   output logic                  tick
);
   logic [DIV_W-1:0] cnt_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= '0;
      end else if (cnt_r == '0) begin
         cnt_r <= divisor;
      end else begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign tick = (cnt_r == '0);
endmodule // baud_tick_gen
`default_nettype wire

// file: xck_edge_detect.sv
// Purpose: synchronise the external transfer clock and find its edges
// Assumes: external clock below a quarter of clk
// Notes:   edges appear two clocks after the pin moves
`timescale 1ns/100ps
`default_nettype none
module xck_edge_detect (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // pin
   input  wire logic xck_in,
   // edges
   output logic      rise,
   output logic      fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // only sync_r reads meta_r
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= xck_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign rise = sync_r & ~last_r;
   assign fall = ~sync_r & last_r;
endmodule // xck_edge_detect
`default_nettype wire

// file: serial_peer.sv
// Purpose: remote serial device on the transmit and receive lines
// Assumes: bench sets the frame format before any traffic
// Notes:   counts a heard frame only when its first stop bit is high
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
   // clock
   input  wire logic       clk,
   // frame format
   input  wire logic [4:0] bit_clks,
   input  wire logic [3:0] nbits,
   input  wire logic       par_en,
   input  wire logic       par_odd,
   // serial lines
   input  wire logic       line_in,
   output logic            line_out,
   // last frame heard
   output logic [8:0]      word,
   output logic            par,
   output logic [7:0]      count
);
   initial begin
      line_out = 1'b1;
      word = 9'h000;
      par = 1'b0;
      count = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // listener: mid-bit sampling from the falling start edge
   always begin
      @(negedge line_in);
      repeat (bit_clks / 2) @(posedge clk);
      word = 9'h000;
      for (int i = 0; i < nbits; i++) begin
         repeat (bit_clks) @(posedge clk);
         word[i] = line_in;
      end
      if (par_en) begin
         repeat (bit_clks) @(posedge clk);
         par = line_in;
      end
      repeat (bit_clks) @(posedge clk);
      if (line_in === 1'b1) count = count + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // talker: line returns high after the stops, never left floating
   task automatic send(input logic [8:0] d, input logic two_stop);
      line_out <= 1'b0;
      repeat (bit_clks) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         line_out <= d[i];
         repeat (bit_clks) @(posedge clk);
      end
      if (par_en) begin
         line_out <= ^d ^ par_odd;
         repeat (bit_clks) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (two_stop ? 2 * bit_clks : bit_clks) @(posedge clk);
   endtask
endmodule // serial_peer
`default_nettype wire

// file: usart_transmit_receive_path_bench.sv
// Purpose: self-checking bench for the serial port core
// Assumes: divisor 0, so a bit lasts 16 clocks (8 at double speed)
// Notes:   sync mode is left to the in-design assertions
`timescale 1ns/100ps
`default_nettype none
`include "usart_defines.svh"
module usart_transmit_receive_path_bench;
   logic        clk;
   logic        reset;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        gie;
   logic        ack;
   logic        be_irq;
   logic        tc_irq;
   logic        tx_pin;
   logic        tx_oe_n;
   logic        rx_pin;
   logic [4:0]  bit_clks;
   logic [3:0]  nbits;
   logic        par_en;
   logic        par_odd;
   logic [8:0]  word;
   logic        par;
   logic [7:0]  count;
   logic [7:0]  n;
   logic [31:0] rd;
   int          miscompares;
   int          tests_run;
   logic [7:0]  fc [4] = '{8'h06, 8'h20, 8'h3C, 8'h06};
   logic [3:0]  fn [4] = '{4'h8, 4'h5, 4'h7, 4'h9};
   logic [2:0]  fb [4] = '{3'h0, 3'h0, 3'h0, 3'h5};
   logic        fu [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   logic [8:0]  fw [4] = '{9'h1A5, 9'h0F6, 9'h0D3, 9'h05A};
   logic [8:0]  fe [4] = '{9'h0A5, 9'h016, 9'h053, 9'h15A};

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   usart_core dut_u (
      .clk                         (clk),
      .reset                       (reset),
      .hsel                        (hsel),
      .haddr                       (haddr),
      .htrans                      (htrans),
      .hwrite                      (hwrite),
      .hsize                       (3'b010),
      .hwdata                      (hwdata),
      .hready                      (hready),
      .hreadyout                   (hready),
      .hresp                       (),
      .hrdata                      (hrdata),
      .global_irq_enable           (gie),
      .tx_complete_irq_ack         (ack),
      .buffer_empty_irq            (be_irq),
      .tx_complete_irq             (tc_irq),
      .port_txd_value              (1'b1),
      .port_txd_oe_n               (1'b1),
      .transmit_data_pin_out       (tx_pin),
      .transmit_data_pin_oe_n      (tx_oe_n),
      .receive_data_pin            (rx_pin),
      .external_transfer_clock_pin (1'b0)
   );

   serial_peer peer_u (
      .clk      (clk),
      .bit_clks (bit_clks),
      .nbits    (nbits),
      .par_en   (par_en),
      .par_odd  (par_odd),
      .line_in  (tx_pin),
      .line_out (rx_pin),
      .word     (word),
      .par      (par),
      .count    (count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic give_up(input int k, input int lim);
      if (k >= lim) begin
         miscompares++;
         stop_test();
      end
   endtask

   // address phase held until hready, then data phase until hready again
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      int k;
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 99);
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge clk);
         k++;
      end while (hready !== 1'b1 && k < 99);
      r = hrdata;
      give_up(k, 99);
   endtask

   task automatic wait_count(input logic [7:0] want);
      int k;
      k = 0;
      while (count !== want && k < 999) begin
         @(posedge clk);
         k++;
      end
      give_up(k, 999);
   endtask

   task automatic wait_rx();
      int k;
      k = 0;
      rd = 32'h0000_0000;
      while (rd[`ST_RXC] !== 1'b1 && k < 999) begin
         bus(`ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
         k++;
      end
      give_up(k, 999);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      gie = 1'b0;
      ack = 1'b0;
      bit_clks = 5'd16;
      nbits = 4'h8;
      par_en = 1'b0;
      par_odd = 1'b0;
      miscompares = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      check("pin at reset", tx_oe_n, 1'b1);
      bus(`ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
      check("status reset", rd, 32'h0000_0020);
      bus(`ADDR_CTRL_C, 1'b0, 32'h0000_0000, rd);
      check("format reset", rd, 32'h0000_0006);
      bus(8'h1C, 1'b0, 32'h0000_0000, rd);
      check("unmapped", rd, 32'h0000_0000);
      // one pass per frame format, out through the transmitter and back in
      for (int i = 0; i < 4; i++) begin
         par_en <= fc[i][5];
         par_odd <= fc[i][4];
         nbits <= fn[i];
         bit_clks <= fu[i] ? 5'd8 : 5'd16;
         bus(`ADDR_CTRL_C, 1'b1, {24'h0, fc[i]}, rd);
         bus(`ADDR_STATUS, 1'b1, {30'h0, fu[i], 1'b0}, rd);
         bus(`ADDR_CTRL_B, 1'b1, {29'h3, fb[i]}, rd);
         @(posedge clk);
         check("pin owned", tx_oe_n, 1'b0);
         n = count;
         bus(`ADDR_DATA, 1'b1, {23'h0, fw[i]}, rd);
         wait_count(n + 8'h01);
         check("tx word", {23'h0, word}, {23'h0, fe[i]});
         if (fc[i][5]) check("tx parity", par, ^fe[i] ^ fc[i][4]);
         peer_u.send(fe[i], fc[i][3]);
         wait_rx();
         bus(`ADDR_CTRL_B, 1'b0, 32'h0000_0000, rd);
         check("rx ninth", rd[`CB_RX9], fe[i][8]);
         bus(`ADDR_DATA, 1'b0, 32'h0000_0000, rd);
         check("rx data", rd, {24'h0, fe[i][7:0]});
      end
      // flags, requests and a deferred disable with two frames queued
      gie <= 1'b1;
      bit_clks <= 5'd16;
      nbits <= 4'h8;
      bus(`ADDR_CTRL_C, 1'b1, 32'h0000_0006, rd);
      bus(`ADDR_CTRL_B, 1'b1, 32'h0000_0078, rd);
      @(posedge clk);
      check("complete irq", tc_irq, 1'b1);
      check("empty irq", be_irq, 1'b1);
      bus(`ADDR_STATUS, 1'b1, 32'h0000_0040, rd);
      bus(`ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
      check("complete w1c", rd, 32'h0000_0020);
      n = count;
      bus(`ADDR_DATA, 1'b1, 32'h0000_0011, rd);
      bus(`ADDR_DATA, 1'b1, 32'h0000_0022, rd);
      bus(`ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
      check("buffer full", rd, 32'h0000_0000);
      check("empty irq low", be_irq, 1'b0);
      bus(`ADDR_CTRL_B, 1'b1, 32'h0000_0070, rd);
      @(posedge clk);
      check("pin kept", tx_oe_n, 1'b0);
      wait_count(n + 8'h02);
      repeat (16) @(posedge clk);
      check("second frame", {23'h0, word}, 32'h0000_0022);
      check("pin released", tx_oe_n, 1'b1);
      bus(`ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
      check("complete set", rd, 32'h0000_0060);
      check("complete irq", tc_irq, 1'b1);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(posedge clk);
      check("serviced irq", tc_irq, 1'b0);
      bus(`ADDR_STATUS, 1'b0, 32'h0000_0000, rd);
      check("serviced flag", rd, 32'h0000_0020);
      stop_test();
   end
endmodule // usart_transmit_receive_path_bench
`default_nettype wire
